//--- src/reset_sequencer.sv
// Reset sequencing, start-up delays and reset-cause recording
// What this block does
// R1: Delay depends on cause and oscillator type
// R2: Power-on clears power-on flag, sets both
// R3: Brown-out, watchdog reset and wake set flags
// R4: Pin reset in run keeps flags, clears bank
// R5: Pin reset in sleep, irq wake: 1,0
// R6: Resets load zero, wakes continue at next except the R7 case
// R7: Irq wake with global enable takes vector
// R8: Irq wake sets the flags that caused it
// R9: Register init class follows the cause
// R10: Watchdog and sleep flags follow cause
// R11: Unimplemented bits read as zero
// R12: Status bit layout bank, flags, arithmetic
// R13: Oscillator count only in crystal modes
// R14: Brown-out always runs the power-up delay
// R15: Reset held until both delays expire
// R16: Power-up delay counted in delay ticks
//
// Added by the designer: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "rst_seq_defs.svh"
module reset_sequencer import rst_seq_pkg::*; #(
   parameter logic [15:0] POWERUP_DELAY_TICKS = 16'(`PWRUP_TICKS) // R16
) (
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic ce_i,
   input wire logic por_i,
   input wire logic brownout_i,
   input wire logic external_reset_pin_n_i,
   input wire logic watchdog_i,
   input wire logic wake_irq_i,
   input wire logic global_irq_enable_i,
   input wire logic sleep_req_i,
   input wire logic [12:0] pc_i,
   input wire logic [7:0] wake_irq_src_i,
   input wire logic [7:0] wake_periph_a_src_i,
   input wire logic [7:0] wake_periph_b_src_i,
   input wire logic delay_osc_i,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic core_reset_o,
   output logic sleeping_o,
   output logic pc_load_o,
   output logic [12:0] pc_value_o,
   output reg_init_t reg_init_o,
   output logic [7:0] core_status_o,
   output logic [7:0] irq_flag_set_o,
   output logic [7:0] periph_a_set_o,
   output logic [7:0] periph_b_set_o,
   output logic irq_o
);
   seq_state_t state;
   cause_t cause_now;
   cause_t cause_reg;
   logic wake_seq_reg;
   logic [12:0] pc_target_reg;
   logic pin_high_reg;
   logic [7:0] core_status_reg;
   logic [1:0] power_control_reg;
   logic [3:0] cfg_reg;
   logic [4:0] irq_status_reg;
   logic [4:0] irq_status_next;
   logic [4:0] irq_mask_reg;
   logic [4:0] irq_set;
   logic [7:0] aw_addr_reg;
   logic [7:0] w_data_reg;
   logic w_strb_reg;
   logic wr_go;
   logic rd_clear;
   logic delay_tick;
   logic pwrt_done;
   logic ost_done;
   logic live;
   logic bor_active;
   logic crystal;
   logic [10:0] ost_age_reg;

   function automatic logic [2:0] reg_index(input logic [7:0] addr);
      case (addr)
         `OFS_CORE_STATUS: reg_index = 3'h0;
         `OFS_POWER_CONTROL: reg_index = 3'h1;
         `OFS_IRQ_STATUS: reg_index = 3'h2;
         `OFS_IRQ_MASK: reg_index = 3'h3;
         `OFS_CONFIG: reg_index = 3'h4;
         default: reg_index = 3'h7;
      endcase
   endfunction : reg_index

   function automatic logic is_crystal(input logic [1:0] mode);
      is_crystal = (mode != `OSC_RESISTOR_CAP);
   endfunction : is_crystal

   assign crystal = is_crystal(cfg_reg[`CFG_OSC_MSB:`CFG_OSC_LSB]);
   assign live = (state == st_run) || (state == st_sleep);
   assign bor_active = brownout_i && cfg_reg[`CFG_BOR_EN_BIT];

   edge_tick u_delay_tick (
      .sys_clk_i(sys_clk_i),
      .reset_i(reset_i),
      .ce_i(ce_i),
      .level_i(delay_osc_i),
      .rise_o(delay_tick)
   );

   startup_counter u_pwrt (
      .sys_clk_i(sys_clk_i),
      .reset_i(reset_i),
      .ce_i(ce_i),
      .run_i(state == st_powerup),
      .step_i(delay_tick), // R16
      .limit_i(POWERUP_DELAY_TICKS),
      .done_o(pwrt_done)
   );

   startup_counter u_ost (
      .sys_clk_i(sys_clk_i),
      .reset_i(reset_i),
      .ce_i(ce_i),
      .run_i(state == st_oscstart),
      .step_i(1'b1),
      .limit_i(16'(`OST_CYCLES)),
      .done_o(ost_done)
   );

   // Cause of this cycle, highest priority first
   always_comb begin
      cause_now = cause_none;
      if (por_i) begin
         cause_now = cause_por;
      end else if (bor_active) begin
         cause_now = cause_bor;
      end else if (live && pin_high_reg && !external_reset_pin_n_i) begin
         cause_now = (state == st_sleep) ? cause_ext_sleep : cause_ext_run;
      end else if (live && watchdog_i) begin
         cause_now = (state == st_sleep) ? cause_wdt_wake : cause_wdt;
      end else if (state == st_sleep && wake_irq_i) begin
         cause_now = cause_irq_wake;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         pin_high_reg <= 1'b1;
      end else if (ce_i) begin
         pin_high_reg <= external_reset_pin_n_i;
      end
   end

   // Sequencer
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         state <= st_supply;
         cause_reg <= cause_por;
         wake_seq_reg <= 1'b0;
         pc_target_reg <= `RESET_VECTOR;
      end else if (ce_i) begin
         if (cause_now != cause_none) begin
            cause_reg <= cause_now;
         end
         case (cause_now)
            cause_por, cause_bor: begin
               state <= st_supply;
               wake_seq_reg <= 1'b0;
               pc_target_reg <= `RESET_VECTOR; // R6
            end
            cause_ext_run, cause_ext_sleep, cause_wdt: begin
               state <= st_pin;
               wake_seq_reg <= 1'b0;
               pc_target_reg <= `RESET_VECTOR; // R6
            end
            cause_wdt_wake, cause_irq_wake: begin
               state <= crystal ? st_oscstart : st_run; // R1 R13
               wake_seq_reg <= 1'b1;
               if (cause_now == cause_irq_wake && global_irq_enable_i) begin
                  pc_target_reg <= `IRQ_VECTOR; // R7
               end else begin
                  pc_target_reg <= pc_i + 13'h0001; // R6
               end
            end
            default: begin
               case (state)
                  st_supply: begin
                     if (cause_reg == cause_bor
                         || !cfg_reg[`CFG_PWRT_DIS_BIT]) begin
                        state <= st_powerup; // R1 R14
                     end else begin
                        state <= crystal ? st_oscstart : st_pin; // R1
                     end
                  end
                  st_powerup: begin
                     if (pwrt_done) begin
                        state <= crystal ? st_oscstart : st_pin; // R15
                     end
                  end
                  st_oscstart: begin
                     if (ost_done) begin
                        state <= wake_seq_reg ? st_run : st_pin; // R15
                     end
                  end
                  st_pin: begin
                     if (external_reset_pin_n_i) begin
                        state <= st_run;
                     end
                  end
                  st_run: begin
                     wake_seq_reg <= 1'b0;
                     if (sleep_req_i) begin
                        state <= st_sleep;
                     end
                  end
                  st_sleep: begin
                     state <= st_sleep;
                  end
                  default: begin
                     state <= st_supply;
                  end
               endcase
            end
         endcase
      end
   end

   // Outputs toward the core
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         core_reset_o <= 1'b1;
         sleeping_o <= 1'b0;
         pc_load_o <= 1'b0;
         pc_value_o <= `RESET_VECTOR;
      end else if (ce_i) begin
         core_reset_o <= !live && !wake_seq_reg; // R15
         sleeping_o <= (state == st_sleep)
                       || (state == st_oscstart && wake_seq_reg);
         pc_load_o <= (state == st_run) && (core_reset_o || sleeping_o);
         pc_value_o <= pc_target_reg; // R6
      end
   end

   // Wake flags and register init class
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         irq_flag_set_o <= 8'h00;
         periph_a_set_o <= 8'h00;
         periph_b_set_o <= 8'h00;
         reg_init_o <= init_full;
      end else if (ce_i) begin
         if (cause_now == cause_irq_wake) begin
            irq_flag_set_o <= wake_irq_src_i; // R8
            periph_a_set_o <= wake_periph_a_src_i; // R8
            periph_b_set_o <= wake_periph_b_src_i; // R8
         end else begin
            irq_flag_set_o <= 8'h00;
            periph_a_set_o <= 8'h00;
            periph_b_set_o <= 8'h00;
         end
         case (cause_now)
            cause_por, cause_bor: reg_init_o <= init_full; // R9
            cause_ext_run, cause_ext_sleep, cause_wdt: begin
               reg_init_o <= init_partial; // R9
            end
            default: reg_init_o <= init_none; // R9
         endcase
      end
   end

   // Status and power control flags; the hardware cause wins over software
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         core_status_reg <= `STATUS_RESET;
         power_control_reg <= `PCTL_RESET;
      end else if (ce_i) begin
         if (wr_go && w_strb_reg) begin
            if (reg_index(aw_addr_reg) == 3'h0) begin
               core_status_reg[7:5] <= w_data_reg[7:5]; // R12
               core_status_reg[2:0] <= w_data_reg[2:0]; // R12
            end
            if (reg_index(aw_addr_reg) == 3'h1) begin
               power_control_reg <= w_data_reg[1:0];
            end
         end
         case (cause_now) // R10
            cause_por: begin
               core_status_reg[7:3] <= 5'h03; // R2
               power_control_reg[`PCTL_POWER_ON_BIT] <= 1'b0; // R2
            end
            cause_bor: begin
               core_status_reg[7:3] <= 5'h03; // R3
               power_control_reg[`PCTL_BROWNOUT_BIT] <= 1'b0; // R3
            end
            cause_ext_run: begin
               core_status_reg[7:5] <= 3'h0; // R4
            end
            cause_ext_sleep: begin
               core_status_reg[7:3] <= 5'h02; // R5
            end
            cause_wdt: begin
               core_status_reg[7:3] <= 5'h01; // R3
            end
            cause_wdt_wake: begin
               core_status_reg[4:3] <= 2'h0; // R3 R6
            end
            cause_irq_wake: begin
               core_status_reg[4:3] <= 2'h2; // R5 R6
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         core_status_o <= `STATUS_RESET;
      end else if (ce_i) begin
         core_status_o <= core_status_reg;
      end
   end

   // Interrupt status: set wins over the clear by read
   always_comb begin
      irq_set = 5'h00;
      irq_set[`IRQ_POR_BIT] = (cause_now == cause_por);
      irq_set[`IRQ_BOR_BIT] = (cause_now == cause_bor);
      irq_set[`IRQ_PIN_BIT] = (cause_now == cause_ext_run)
                              || (cause_now == cause_ext_sleep);
      irq_set[`IRQ_WDOG_BIT] = (cause_now == cause_wdt);
      irq_set[`IRQ_WAKE_BIT] = (cause_now == cause_wdt_wake)
                               || (cause_now == cause_irq_wake);
      irq_status_next = (rd_clear ? 5'h00 : irq_status_reg) | irq_set;
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         irq_status_reg <= 5'h00;
         irq_o <= 1'b0;
      end else if (ce_i) begin
         irq_status_reg <= irq_status_next;
         irq_o <= |(irq_status_next & irq_mask_reg);
      end
   end

   // Software configuration and mask
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         cfg_reg <= `CFG_RESET;
         irq_mask_reg <= `IRQ_MASK_RESET;
      end else if (ce_i && wr_go && w_strb_reg) begin
         if (reg_index(aw_addr_reg) == 3'h3) begin
            irq_mask_reg <= w_data_reg[4:0];
         end
         if (reg_index(aw_addr_reg) == 3'h4) begin
            cfg_reg <= w_data_reg[3:0];
         end
      end
   end

   // Bus write channel
   assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `AXI_OKAY;
         aw_addr_reg <= 8'h00;
         w_data_reg <= 8'h00;
         w_strb_reg <= 1'b0;
      end else if (ce_i) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_addr_reg <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_data_reg <= s_axi_wdata[7:0];
            w_strb_reg <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
         end
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (reg_index(aw_addr_reg) == 3'h7)
                           ? `AXI_SLVERR : `AXI_OKAY;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // Bus read channel
   assign rd_clear = s_axi_arvalid && s_axi_arready
                     && (reg_index(s_axi_araddr) == 3'h2);

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `AXI_OKAY;
      end else if (ce_i) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `AXI_OKAY;
            case (reg_index(s_axi_araddr)) // R11
               3'h0: s_axi_rdata <= {24'h000000, core_status_reg};
               3'h1: s_axi_rdata <= {30'h00000000, power_control_reg};
               3'h2: s_axi_rdata <= {27'h0000000, irq_status_reg};
               3'h3: s_axi_rdata <= {27'h0000000, irq_mask_reg};
               3'h4: s_axi_rdata <= {28'h0000000, cfg_reg};
               default: begin
                  s_axi_rdata <= 32'h00000000;
                  s_axi_rresp <= `AXI_SLVERR;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   // Checking helpers and properties
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         ost_age_reg <= 11'h000;
      end else if (ce_i) begin
         ost_age_reg <= (state == st_oscstart) ? ost_age_reg + 11'h001
                                               : 11'h000;
      end
   end

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);

   por_flags_a: assert property (ce_i && cause_now == cause_por |=> // R2
      core_status_reg[4:3] == 2'h3 && !power_control_reg[1])
      else $error("power-on flags wrong");
   bor_flags_a: assert property (ce_i && cause_now == cause_bor |=> // R3
      !power_control_reg[0] && core_status_reg[7:3] == 5'h03
      && power_control_reg[1] == $past(power_control_reg[1]))
      else $error("brown-out flags wrong");
   wdt_flags_a: assert property (ce_i && cause_now == cause_wdt |=> // R3
      core_status_reg[7:3] == 5'h01)
      else $error("watchdog reset flags wrong");
   pin_run_a: assert property (ce_i && cause_now == cause_ext_run |=> // R4
      core_status_reg[4:0] == $past(core_status_reg[4:0])
      && core_status_reg[7:5] == 3'h0)
      else $error("pin reset changed flags");
   pin_sleep_a: assert property (ce_i && (cause_now == cause_ext_sleep // R5
      || cause_now == cause_irq_wake) |=> core_status_reg[4:3] == 2'h2)
      else $error("sleep pin or wake flags wrong");
   reset_pc_a: assert property ($fell(core_reset_o) |-> // R6
      pc_load_o && pc_value_o == `RESET_VECTOR)
      else $error("reset release without zero start");
   irq_vector_a: assert property (ce_i && cause_now == cause_irq_wake // R7
      && global_irq_enable_i |=> pc_target_reg == `IRQ_VECTOR)
      else $error("wake did not take the vector");
   wake_flags_a: assert property (ce_i && cause_now == cause_irq_wake |=> // R8
      irq_flag_set_o == $past(wake_irq_src_i))
      else $error("wake source flags not set");
   bor_delay_a: assert property (ce_i && state == st_supply // R14
      && cause_reg == cause_bor && !por_i && !bor_active
      |=> state == st_powerup)
      else $error("brown-out skipped power-up delay");
   ost_length_a: assert property ($past(state) == st_oscstart // R13
      && state != st_oscstart && state != st_supply
      |-> ost_age_reg == 11'(`OST_CYCLES + 1))
      else $error("oscillator count length wrong");
   held_reset_a: assert property (ce_i && state == st_powerup // R15
      && !wake_seq_reg ##1 ce_i |=> core_reset_o)
      else $error("reset released during power-up delay");
   rsvd_zero_a: assert property (s_axi_rvalid |-> // R11
      s_axi_rdata[31:8] == 24'h000000)
      else $error("unimplemented bits not zero");
endmodule : reset_sequencer

//--- src/rst_seq_defs.svh
// Offsets, field positions, reset values and timing counts of the sequencer
`ifndef RST_SEQ_DEFS_SVH
`define RST_SEQ_DEFS_SVH

`define OFS_CORE_STATUS 8'h00
`define OFS_POWER_CONTROL 8'h04
`define OFS_IRQ_STATUS 8'h08
`define OFS_IRQ_MASK 8'h0C
`define OFS_CONFIG 8'h10

`define ST_UPPER_MSB 7
`define ST_UPPER_LSB 5
`define ST_WDOG_BIT 4
`define ST_SLEEP_BIT 3
`define ST_LOW_MSB 2
`define PCTL_POWER_ON_BIT 1
`define PCTL_BROWNOUT_BIT 0

`define CFG_OSC_MSB 1
`define CFG_OSC_LSB 0
`define CFG_PWRT_DIS_BIT 2
`define CFG_BOR_EN_BIT 3
`define OSC_RESISTOR_CAP 2'h3

`define STATUS_RESET 8'h18
`define PCTL_RESET 2'h0
`define CFG_RESET 4'h8
`define IRQ_MASK_RESET 5'h00

`define IRQ_POR_BIT 0
`define IRQ_BOR_BIT 1
`define IRQ_PIN_BIT 2
`define IRQ_WDOG_BIT 3
`define IRQ_WAKE_BIT 4

`define PWRUP_DELAY_MS 72
`define DELAY_OSC_HZ 32768
`define PWRUP_TICKS ((`PWRUP_DELAY_MS * `DELAY_OSC_HZ + 999) / 1000)
`define OST_CYCLES 1024

`define RESET_VECTOR 13'h0000
`define IRQ_VECTOR 13'h0004
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2

`endif

//--- src/rst_seq_pkg.sv
// Types shared by the reset sequencer
package rst_seq_pkg;
   typedef enum logic [2:0] {
      st_supply, st_powerup, st_oscstart, st_pin, st_run, st_sleep
   } seq_state_t;
   typedef enum logic [2:0] {
      cause_none, cause_por, cause_bor, cause_ext_run, cause_ext_sleep,
      cause_wdt, cause_wdt_wake, cause_irq_wake
   } cause_t;
   typedef enum logic [1:0] {init_none, init_full, init_partial} reg_init_t;
endpackage : rst_seq_pkg

//--- src/startup_counter.sv
// Down counter that times one start-up interval
`timescale 1ns/1ps
module startup_counter (
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic ce_i,
   input wire logic run_i,
   input wire logic step_i,
   input wire logic [15:0] limit_i,
   output logic done_o
);
   logic [15:0] count_reg;

   // Reloads whenever idle, so each interval starts from the full limit
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         count_reg <= 16'h0000;
      end else if (ce_i) begin
         if (!run_i) begin
            count_reg <= limit_i;
         end else if (step_i && count_reg != 16'h0000) begin
            count_reg <= count_reg - 16'h0001;
         end
      end
   end

   assign done_o = run_i && (count_reg == 16'h0000);
endmodule : startup_counter

//--- src/edge_tick.sv
// Rising-edge detector for the delay oscillator input
`timescale 1ns/1ps
module edge_tick (
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic ce_i,
   input wire logic level_i,
   output logic rise_o
);
   logic level_reg;

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         level_reg <= 1'b0;
         rise_o <= 1'b0;
      end else if (ce_i) begin
         level_reg <= level_i;
         rise_o <= level_i && !level_reg;
      end
   end
endmodule : edge_tick

//--- verif/supply_partner.sv
// Supply monitors, reset pin, watchdog and delay oscillator model
`timescale 1ns/1ps
module supply_partner (
   input wire logic sys_clk_i,
   output logic por_o,
   output logic brownout_o,
   output logic pin_n_o,
   output logic watchdog_o,
   output logic delay_osc_o
);
   logic [1:0] div_reg = 2'h0;
   initial begin
      por_o = 1'b1;
      brownout_o = 1'b0;
      pin_n_o = 1'b1;
      watchdog_o = 1'b0;
      delay_osc_o = 1'b0;
   end
   // Delay oscillator runs free, eight system cycles a period
   always @(posedge sys_clk_i) begin
      div_reg <= div_reg + 2'h1;
      if (div_reg == 2'h3) delay_osc_o <= ~delay_osc_o;
   end
   task power_good();
      @(posedge sys_clk_i);
      por_o <= 1'b0;
   endtask : power_good
   task watchdog_bite();
      @(posedge sys_clk_i);
      watchdog_o <= 1'b1;
      @(posedge sys_clk_i);
      watchdog_o <= 1'b0;
   endtask : watchdog_bite
   task pin_reset();
      @(posedge sys_clk_i);
      pin_n_o <= 1'b0;
      repeat (4) @(posedge sys_clk_i);
      pin_n_o <= 1'b1;
   endtask : pin_reset
   task brown_dip();
      @(posedge sys_clk_i);
      brownout_o <= 1'b1;
      repeat (4) @(posedge sys_clk_i);
      brownout_o <= 1'b0;
   endtask : brown_dip
endmodule : supply_partner

//--- verif/reset_sequencer_tb_top.sv
// Self-checking testbench for the reset sequencer
`timescale 1ns/1ps
module reset_sequencer_tb_top;
   logic sys_clk_i = 0, reset_i = 1, slp = 0, wake = 0, global_irq_enable = 0;
   logic por, bod, pin_n, wdog, dosc, awready, wready, bvalid, arready;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic rvalid, core_reset, pc_load, irq, sleeping;
   logic [12:0] pc = 13'h0, pc_value;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, status, flags;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic [1:0] bresp, rresp, r, init;
   logic [3:0] strb = 4'hF;
   int mismatches = 0, checks_done = 0, cycles = 0, n;
   always #25 sys_clk_i = ~sys_clk_i;
   supply_partner u_supply_partner (.sys_clk_i(sys_clk_i), .por_o(por),
      .brownout_o(bod), .pin_n_o(pin_n), .watchdog_o(wdog),
      .delay_osc_o(dosc));
   reset_sequencer #(.POWERUP_DELAY_TICKS(16'h0004)) u_reset_sequencer (
      .sys_clk_i(sys_clk_i), .reset_i(reset_i), .ce_i(1'b1), .por_i(por),
      .brownout_i(bod), .external_reset_pin_n_i(pin_n), .watchdog_i(wdog),
      .wake_irq_i(wake), .global_irq_enable_i(global_irq_enable), .sleep_req_i(slp),
      .pc_i(pc), .wake_irq_src_i(8'h01), .wake_periph_a_src_i(8'h02),
      .wake_periph_b_src_i(8'h04), .delay_osc_i(dosc),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .core_reset_o(core_reset), .sleeping_o(sleeping),
      .pc_load_o(pc_load), .pc_value_o(pc_value), .reg_init_o(init),
      .core_status_o(status), .irq_flag_set_o(flags), .periph_a_set_o(),
      .periph_b_set_o(), .irq_o(irq));
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge sys_clk_i);
      awaddr <= a;
      wdata <= {24'h0, v};
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      forever begin
         @(posedge sys_clk_i);
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
         if (bvalid) break;
      end
      r = bresp;
      bready <= 0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge sys_clk_i);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      forever begin
         @(posedge sys_clk_i);
         if (arready) arvalid <= 0;
         if (rvalid) break;
      end
      d = rdata;
      r = rresp;
      rready <= 0;
   endtask : rd
   // Counts cycles until the core is let go and checks the reset vector
   task automatic release_wait();
      n = 0;
      while (core_reset !== 1) @(posedge sys_clk_i);
      while (pc_load !== 1) begin
         @(posedge sys_clk_i);
         n++;
      end
      check({31'h0, core_reset}, 32'h0);
      check({19'h0, pc_value}, 32'h0);
   endtask : release_wait
   task automatic t_power_up();
      u_supply_partner.power_good();
      release_wait();
      check({31'h0, n > 1048 && n < 1100}, 32'h1);
      check({24'h0, status}, 32'h18);
      rd(8'h04);
      check(d, 32'h0);
      rd(8'h0C);
      check(d, 32'h0);
      $display("power-up test done");
   endtask : t_power_up
   task automatic t_brownout();
      wr(8'h10, 8'h0C);
      wr(8'h04, 8'h03);
      u_supply_partner.brown_dip();
      release_wait();
      check({31'h0, n > 1048}, 32'h1);
      check({24'h0, status}, 32'h18);
      rd(8'h04);
      check(d, 32'h2);
      $display("brown-out test done");
   endtask : t_brownout
   task automatic t_watchdog();
      u_supply_partner.watchdog_bite();
      @(posedge sys_clk_i);
      check({30'h0, init}, 32'h2);
      release_wait();
      check({24'h0, status}, 32'h08);
      $display("watchdog test done");
   endtask : t_watchdog
   task automatic t_pin();
      wr(8'h00, 8'hFF);
      rd(8'h00);
      check(d, 32'hEF);
      u_supply_partner.pin_reset();
      release_wait();
      check({24'h0, status}, 32'h0F);
      $display("pin reset test done");
   endtask : t_pin
   task automatic t_wake(input logic g, input logic [12:0] exp);
      slp <= 1;
      @(posedge sys_clk_i);
      slp <= 0;
      repeat (2) @(posedge sys_clk_i);
      pc <= 13'h123;
      global_irq_enable <= g;
      wake <= 1;
      @(posedge sys_clk_i);
      wake <= 0;
      @(posedge sys_clk_i);
      check({24'h0, flags}, 32'h01);
      check({31'h0, sleeping}, 32'h1);
      while (pc_load !== 1) @(posedge sys_clk_i);
      check({19'h0, pc_value}, {19'h0, exp});
      check({24'h0, status}, 32'h17);
      $display("wake test done");
   endtask : t_wake
   task automatic t_irq();
      check({31'h0, irq}, 32'h0);
      wr(8'h0C, 8'h10);
      @(posedge sys_clk_i);
      check({31'h0, irq}, 32'h1);
      // Write with byte lane 0 off must be ignored
      strb <= 4'h0;
      wr(8'h0C, 8'h00);
      strb <= 4'hF;
      rd(8'h0C);
      check(d, 32'h10);
      rd(8'h08);
      check(d & 32'h10, 32'h10);
      repeat (3) @(posedge sys_clk_i);
      check({31'h0, irq}, 32'h0);
      rd(8'h1C);
      check({30'h0, r}, 32'h2);
      check(d, 32'h0);
      $display("interrupt test done");
   endtask : t_irq
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : stop_test
   always @(posedge sys_clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         stop_test();
      end
   end
   initial begin
      repeat (3) @(posedge sys_clk_i);
      reset_i <= 0;
      t_power_up();
      t_brownout();
      t_watchdog();
      t_pin();
      t_wake(1'b1, 13'h004);
      t_wake(1'b0, 13'h124);
      t_irq();
      stop_test();
   end
endmodule : reset_sequencer_tb_top
